// [esyn_pkg.sv]
// Purpose: Shared types and constants for the exception syndrome unit
// Assumes: One core clock, synchronous active-high reset
// Notes:   Tags below mark the logic that keeps each rule
// Function
// RL1 - Feature view: EL3 always, EL1/2 per bit5
// RL2 - Feature view access from EL0 is undefined
// RL3 - Error-trap bit traps non-secure EL1 to EL2
// RL4 - Monitor error-trap bit traps EL1/EL2 to EL3
// RL5 - Status view selects record 0 or 1
// RL6 - Level 1/3 syndrome field layout fixed
// RL7 - Length bit: 0 short, 1 long instruction
// RL8 - Length bit forced 1 for listed causes
// RL9 - Syndrome info zero unless valid bit set
// RL10 - System error class carries chosen info
// RL11 - Level 2 info bits 24:0, virtual copy
// RL12 - Physical system error: format 0, severity, kind 0
// RL13 - Data abort at level 2: kind bit zero
// RL14 - Hyp auxiliary register reads zero, no effect
// RL15 - Hyp config bits 63:38 read zero
// RL16 - Bit 31 selects lower-level execution state
// RL17 - Hyp call disable bit reads zero
// RL18 - Level 2 syndrome zero without level 2
// RL19 - General trap routes level 1 to level 2
// RL20 - Secure state masks general trap effect
// RL21 - Syndrome written on exception take
package esyn_pkg;
    typedef enum logic [2:0] {
        REG_SYN1, REG_SYN2, REG_SYN3, REG_HAUX,
        REG_HCFG, REG_PFGF, REG_RSTS, REG_NONE
    } esyn_reg_t;
    typedef enum logic [2:0] {
        EK_SYNC, EK_SERR, EK_IABT, EK_PCAL,
        EK_SPAL, EK_DABT, EK_ILST
    } esyn_kind_t;
    localparam int          EC_HI        = 31;
    localparam int          EC_LO        = 26;
    localparam int          IL_BIT       = 25;
    localparam int          SV_BIT       = 24;
    localparam int          ISS_HI       = 23;
    localparam int          ISS2_HI      = 24;
    localparam int          IDS_BIT      = 24;
    localparam int          AET_HI       = 12;
    localparam int          AET_LO       = 10;
    localparam int          EA_BIT       = 9;
    localparam logic [5:0]  EC_ZERO      = 6'h00;
    localparam logic [5:0]  EC_SERR      = 6'h2F;
    localparam logic [2:0]  AET_UC       = 3'h0;
    localparam logic [2:0]  AET_UEU      = 3'h1;
    localparam int          HCFG_RW      = 31;
    localparam int          HCFG_TGE     = 27;
    localparam int          HCFG_ERROR_REG_ACCESS_TRAP    = 36;
    localparam logic [63:0] HCFG_WMASK   = 64'h0000_003F_DFFF_FFFF;
    localparam logic [63:0] HCFG_RST     = 64'h0000_0000_0000_0000;
    localparam logic [31:0] SYN_RST      = 32'h0000_0000;
    localparam logic [1:0]  EL0          = 2'h0;
    localparam logic [1:0]  EL1          = 2'h1;
    localparam logic [1:0]  EL2          = 2'h2;
    localparam logic [1:0]  EL3          = 2'h3;
    typedef struct packed {
        logic        valid;
        logic        write;
        esyn_reg_t   sel;
        logic [1:0]  el;
        logic [63:0] wdata;
    } esyn_req_t;
    typedef struct packed {
        logic        valid;
        logic [63:0] rdata;
        logic        undef;
        logic        trap2;
        logic        trap3;
    } esyn_rsp_t;
    typedef struct packed {
        logic        valid;
        logic [1:0]  target;
        logic [5:0]  cls;
        logic        is32;
        esyn_kind_t  kind;
        logic        abort_syndrome_valid;
        logic        synv;
        logic        unrec;
        logic        virt;
        logic [24:0] info;
    } esyn_take_t;
endpackage

// [esyn_acc_chk.sv]
// Purpose: Access check for the selected feature view register
// Assumes: Enable bits come from the auxiliary control registers
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/100ps
module esyn_acc_chk (
    input  wire logic       [1:0] el_i,
    input  wire logic             aux2_en_i,
    input  wire logic             aux3_en_i,
    input  wire logic             hcr_error_reg_access_trap_i,
    input  wire logic             scr_error_reg_access_trap_i,
    input  wire logic             ns_i,
    output logic                  undef_o,
    output logic                  trap2_o,
    output logic                  trap3_o
);
    import esyn_pkg::*;
    always_comb begin
        undef_o = 1'b0;
        trap2_o = 1'b0;
        trap3_o = 1'b0;
        unique case (el_i)
            EL0: undef_o = 1'b1; // [RL2]
            EL1: begin
                if (!(aux2_en_i && aux3_en_i)) begin
                    undef_o = 1'b1; // [RL1]
                end else if (hcr_error_reg_access_trap_i && ns_i) begin
                    trap2_o = 1'b1; // [RL3]
                end else if (scr_error_reg_access_trap_i) begin
                    trap3_o = 1'b1; // [RL4]
                end
            end
            EL2: begin
                if (!aux3_en_i) begin
                    undef_o = 1'b1; // [RL1]
                end else if (scr_error_reg_access_trap_i) begin
                    trap3_o = 1'b1; // [RL4]
                end
            end
            EL3: undef_o = 1'b0; // [RL1]
        endcase
    end
endmodule

// [esyn_synd_build.sv]
// Purpose: Builds syndrome words for an exception being taken
// Assumes: Caller picks the word for the routed target level
// Notes:   Combinational
`timescale 1ns/100ps
module esyn_synd_build (
    input  wire esyn_pkg::esyn_take_t take_i,
    input  wire logic          [24:0] vsesr_i,
    output logic               [31:0] syn13_o,
    output logic               [31:0] syn2_o
);
    import esyn_pkg::*;
    logic il;
    always_comb begin
        il = take_i.is32; // [RL7]
        if (take_i.kind == EK_SERR || take_i.kind == EK_IABT ||
            take_i.kind == EK_PCAL || take_i.kind == EK_SPAL ||
            take_i.kind == EK_ILST || take_i.cls == EC_ZERO ||
            (take_i.kind == EK_DABT && !take_i.abort_syndrome_valid)) begin
            il = 1'b1; // [RL8]
        end
    end
    always_comb begin
        syn13_o = SYN_RST;
        syn13_o[EC_HI:EC_LO] = take_i.cls; // [RL6]
        syn13_o[IL_BIT] = il;
        syn13_o[SV_BIT] = take_i.synv;
        // System error info is passed through as chosen content
        if (take_i.synv) begin
            syn13_o[ISS_HI:0] = take_i.info[ISS_HI:0]; // [RL9] [RL10]
        end
    end
    always_comb begin
        syn2_o = SYN_RST;
        syn2_o[EC_HI:EC_LO] = take_i.cls;
        syn2_o[IL_BIT] = il;
        syn2_o[ISS2_HI:0] = take_i.info; // [RL11]
        if (take_i.kind == EK_SERR && take_i.virt) begin
            syn2_o[ISS2_HI:0] = vsesr_i; // [RL11]
        end else if (take_i.kind == EK_SERR) begin
            syn2_o[IDS_BIT] = 1'b0; // [RL12]
            syn2_o[AET_HI:AET_LO] = take_i.unrec ? AET_UEU : AET_UC;
            syn2_o[EA_BIT] = 1'b0; // [RL12]
        end else if (take_i.kind == EK_DABT) begin
            syn2_o[EA_BIT] = 1'b0; // [RL13]
        end
    end
endmodule

// [esyn_top.sv]
// Purpose: Syndrome registers, hyp config and error view traps
// Assumes: Requests and takes come from same-clock core logic
// Notes:   Answers one cycle after a request; take beats write
`timescale 1ns/100ps
module esyn_top #(
    parameter bit EL2_IMPL = 1'b1,
    parameter int NREC     = 2
) (
    input  wire logic                   mclk_i,
    input  wire logic                   srst_i,
    input  wire esyn_pkg::esyn_req_t    req_i,
    input  wire esyn_pkg::esyn_take_t   take_i,
    input  wire logic            [24:0] vsesr_i,
    input  wire logic                   scr_ns_i,
    input  wire logic                   scr_error_reg_access_trap_i,
    input  wire logic                   aux2_err_en_i,
    input  wire logic                   aux3_err_en_i,
    input  wire logic                   exec_state_flag_i,
    input  wire logic [$clog2(NREC)-1:0] rec_selector_i,
    input  wire logic [NREC-1:0][63:0]  rec_status_i,
    input  wire logic [NREC-1:0][63:0]  rec_feature_i,
    output esyn_pkg::esyn_rsp_t         rsp_o,
    output logic                        taken_valid_o,
    output logic                  [1:0] taken_el_o,
    output logic                        rec_wr_o,
    output logic [$clog2(NREC)-1:0]     rec_idx_o,
    output logic                 [63:0] rec_wdata_o,
    output logic                        el1_wide_o,
    output logic                        el0_wide_o,
    output logic                        gen_trap_eff_o
);
    import esyn_pkg::*;

    logic [31:0] syn_r [3];
    logic [63:0] hcfg_r;
    esyn_rsp_t   rsp_r;
    logic        taken_valid_r;
    logic [1:0]  taken_el_r;
    logic        rec_wr_r;
    logic [$clog2(NREC)-1:0] rec_idx_r;
    logic [63:0] rec_wdata_r;
    logic        el1_wide_r;
    logic        el0_wide_r;
    logic        gen_trap_r;

    logic        eff_tge;
    logic [1:0]  route_el;
    logic [31:0] syn13;
    logic [31:0] syn2;
    logic        pf_undef;
    logic        pf_trap2;
    logic        pf_trap3;
    logic        undef_nxt;
    logic        trap2_nxt;
    logic        trap3_nxt;
    logic [63:0] rdata_nxt;
    logic        wr_ok;

    // Secure state hides the general trap except for direct access
    assign eff_tge = hcfg_r[HCFG_TGE] & scr_ns_i; // [RL20]

    always_comb begin
        route_el = take_i.target;
        if (take_i.target == EL1 && eff_tge) begin
            route_el = EL2; // [RL19]
        end
    end

    esyn_synd_build u_build (
        .take_i  (take_i),
        .vsesr_i (vsesr_i),
        .syn13_o (syn13),
        .syn2_o  (syn2)
    );

    esyn_acc_chk u_chk (
        .el_i       (req_i.el),
        .aux2_en_i  (aux2_err_en_i),
        .aux3_en_i  (aux3_err_en_i),
        .hcr_error_reg_access_trap_i (hcfg_r[HCFG_ERROR_REG_ACCESS_TRAP]),
        .scr_error_reg_access_trap_i (scr_error_reg_access_trap_i),
        .ns_i       (scr_ns_i),
        .undef_o    (pf_undef),
        .trap2_o    (pf_trap2),
        .trap3_o    (pf_trap3)
    );

    // Access legality for every register this block answers
    always_comb begin
        undef_nxt = 1'b0;
        trap2_nxt = 1'b0;
        trap3_nxt = 1'b0;
        unique case (req_i.sel)
            REG_SYN1: undef_nxt = (req_i.el < EL1);
            REG_SYN2,
            REG_HAUX,
            REG_HCFG: undef_nxt = (req_i.el < EL2);
            REG_SYN3: undef_nxt = (req_i.el != EL3);
            REG_PFGF: begin
                // Feature view is read only; a write is undefined
                undef_nxt = pf_undef | req_i.write;
                trap2_nxt = pf_trap2 & ~req_i.write;
                trap3_nxt = pf_trap3 & ~req_i.write;
            end
            REG_RSTS: undef_nxt = (req_i.el < EL1);
            REG_NONE: undef_nxt = 1'b1;
            default:  undef_nxt = 1'b1;
        endcase
    end

    assign wr_ok = req_i.valid & req_i.write &
                   ~undef_nxt & ~trap2_nxt & ~trap3_nxt;

    // Read data for the answer
    always_comb begin
        rdata_nxt = 64'h0000_0000_0000_0000;
        unique case (req_i.sel)
            REG_SYN1: rdata_nxt[31:0] = syn_r[0];
            REG_SYN2: rdata_nxt[31:0] = syn_r[1];
            REG_SYN3: rdata_nxt[31:0] = syn_r[2];
            REG_HAUX: rdata_nxt = 64'h0000_0000_0000_0000; // [RL14]
            REG_HCFG: rdata_nxt = hcfg_r;
            REG_PFGF: rdata_nxt = rec_feature_i[rec_selector_i];
            REG_RSTS: begin
                rdata_nxt = rec_status_i[rec_selector_i]; // [RL5]
            end
            REG_NONE: rdata_nxt = 64'h0000_0000_0000_0000;
            default:  rdata_nxt = 64'h0000_0000_0000_0000;
        endcase
        if (undef_nxt || trap2_nxt || trap3_nxt) begin
            rdata_nxt = 64'h0000_0000_0000_0000;
        end
    end

    // Syndrome registers, one per target level
    for (genvar i = 0; i < 3; i++) begin : g_syn
        localparam esyn_reg_t  RID = (i == 0) ? REG_SYN1 :
                                     (i == 1) ? REG_SYN2 : REG_SYN3;
        localparam logic [1:0] LVL = 2'(i + 1);
        logic [31:0] sw_val;
        always_comb begin
            sw_val = req_i.wdata[31:0];
            if (i != 1 && !sw_val[SV_BIT]) begin
                sw_val[ISS_HI:0] = 24'h00_0000; // [RL9]
            end
        end
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                syn_r[i] <= SYN_RST;
            end else if (i == 1 && !EL2_IMPL) begin
                syn_r[i] <= SYN_RST; // [RL18]
            end else if (take_i.valid && route_el == LVL) begin
                // Written at the take edge, readable next cycle
                syn_r[i] <= (i == 1) ? syn2 : syn13; // [RL21]
            end else if (wr_ok && req_i.sel == RID) begin
                syn_r[i] <= sw_val; // [RL6]
            end
        end
    end

    // Hyp config; reserved and unimplemented bits never store
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hcfg_r <= HCFG_RST;
        end else if (!EL2_IMPL) begin
            hcfg_r <= HCFG_RST;
        end else if (wr_ok && req_i.sel == REG_HCFG) begin
            hcfg_r <= req_i.wdata & HCFG_WMASK; // [RL15] [RL17]
        end
    end

    // Answer to a register request
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= req_i.valid;
            rsp_r.rdata <= req_i.valid ? rdata_nxt : 64'h0000_0000_0000_0000;
            rsp_r.undef <= req_i.valid & undef_nxt;
            rsp_r.trap2 <= req_i.valid & trap2_nxt;
            rsp_r.trap3 <= req_i.valid & trap3_nxt;
        end
    end

    // Status view writes go to the selected record
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rec_wr_r    <= 1'b0;
            rec_idx_r   <= '0;
            rec_wdata_r <= 64'h0000_0000_0000_0000;
        end else begin
            rec_wr_r <= wr_ok && req_i.sel == REG_RSTS; // [RL5]
            if (req_i.valid) begin
                rec_idx_r <= rec_selector_i;
            end
            if (wr_ok && req_i.sel == REG_RSTS) begin
                rec_wdata_r <= req_i.wdata;
            end
        end
    end

    // Routed take report
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            taken_valid_r <= 1'b0;
            taken_el_r    <= EL0;
        end else begin
            taken_valid_r <= take_i.valid;
            if (take_i.valid) begin
                taken_el_r <= route_el; // [RL19]
            end
        end
    end

    // Lower-level execution state; flag low means the wide state
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            el1_wide_r <= 1'b0;
            el0_wide_r <= 1'b0;
            gen_trap_r <= 1'b0;
        end else begin
            el1_wide_r <= hcfg_r[HCFG_RW]; // [RL16]
            el0_wide_r <= hcfg_r[HCFG_RW] & ~exec_state_flag_i; // [RL16]
            gen_trap_r <= eff_tge; // [RL20]
        end
    end

    assign rsp_o          = rsp_r;
    assign taken_valid_o  = taken_valid_r;
    assign taken_el_o     = taken_el_r;
    assign rec_wr_o       = rec_wr_r;
    assign rec_idx_o      = rec_idx_r;
    assign rec_wdata_o    = rec_wdata_r;
    assign el1_wide_o     = el1_wide_r;
    assign el0_wide_o     = el0_wide_r;
    assign gen_trap_eff_o = gen_trap_r;
endmodule

// [esyn_top_assertions.sv]
// Purpose: Port assertions for the syndrome and trap unit
// Assumes: Bound to esyn_top, single clock domain
// Notes:   Refusals are judged by the flag pulses of the answer
`timescale 1ns/100ps
module esyn_top_assertions
    import esyn_pkg::*;
#(
    parameter bit EL2_IMPL = 1'b1,
    parameter int NREC     = 2
) (
    input wire logic                     mclk_i,
    input wire logic                     srst_i,
    input wire esyn_pkg::esyn_req_t      req_i,
    input wire esyn_pkg::esyn_take_t     take_i,
    input wire logic              [24:0] vsesr_i,
    input wire logic                     scr_ns_i,
    input wire logic                     scr_error_reg_access_trap_i,
    input wire logic                     aux2_err_en_i,
    input wire logic                     aux3_err_en_i,
    input wire logic                     exec_state_flag_i,
    input wire logic [$clog2(NREC)-1:0]  rec_selector_i,
    input wire logic [NREC-1:0][63:0]    rec_status_i,
    input wire logic [NREC-1:0][63:0]    rec_feature_i,
    input wire esyn_pkg::esyn_rsp_t      rsp_o,
    input wire logic                     taken_valid_o,
    input wire logic               [1:0] taken_el_o,
    input wire logic                     rec_wr_o,
    input wire logic [$clog2(NREC)-1:0]  rec_idx_o,
    input wire logic              [63:0] rec_wdata_o,
    input wire logic                     el1_wide_o,
    input wire logic                     el0_wide_o,
    input wire logic                     gen_trap_eff_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // Read of the feature view, the only place the trap flags arise
    wire pf = req_i.valid && !req_i.write && req_i.sel == REG_PFGF;
    wire rd = req_i.valid && !req_i.write && req_i.el[1];

    a_pfgf_el0_undef:
        assert property (pf && req_i.el == EL0 |=> rsp_o.undef)
        else $error("feature view read at level 0 not undefined");
    a_pfgf_el3_open:
        assert property (pf && req_i.el == EL3 |=> rsp_o.valid
            && !rsp_o.undef && !rsp_o.trap2 && !rsp_o.trap3)
        else $error("feature view refused at level 3");
    a_pfgf_el2_gate:
        assert property (pf && req_i.el == EL2 && !aux3_err_en_i
            |=> rsp_o.undef)
        else $error("feature view open at level 2 without enable");
    a_pfgf_trap3:
        assert property (pf && req_i.el == EL2 && aux3_err_en_i
            && scr_error_reg_access_trap_i |=> rsp_o.trap3 && !rsp_o.undef)
        else $error("level 2 feature view read not trapped");
    a_refused_zero:
        assert property (rsp_o.undef || rsp_o.trap2 || rsp_o.trap3
            |-> rsp_o.rdata == 0)
        else $error("refused access returned data");
    a_take_done:
        assert property (take_i.valid |=> taken_valid_o)
        else $error("take not acknowledged next cycle");
    a_secure_route:
        assert property (take_i.valid && take_i.target == EL1
            && !scr_ns_i |=> taken_el_o == EL1)
        else $error("secure level 1 take was rerouted");
    a_tge_masked:
        assert property (!scr_ns_i |=> !gen_trap_eff_o)
        else $error("general trap effective in secure state");
    a_el0_state:
        assert property (el0_wide_o |-> el1_wide_o
            && !$past(exec_state_flag_i))
        else $error("level 0 state disagrees with controls");
    a_status_write:
        assert property (req_i.valid && req_i.write && req_i.el != EL0
            && req_i.sel == REG_RSTS |=> rec_wr_o
            && rec_wdata_o == $past(req_i.wdata)
            && rec_idx_o == $past(rec_selector_i))
        else $error("status view write not passed on");
    a_hcfg_rsvd:
        assert property (rd && req_i.sel == REG_HCFG
            |=> rsp_o.rdata[63:38] == 0 && !rsp_o.rdata[29])
        else $error("reserved hyp config bits read nonzero");
    a_haux_zero:
        assert property (rd && req_i.sel == REG_HAUX |=> rsp_o.rdata == 0)
        else $error("hyp auxiliary register read nonzero");
endmodule

bind esyn_top esyn_top_assertions #(.EL2_IMPL(EL2_IMPL), .NREC(NREC)) u_sva (
    .mclk_i(mclk_i), .srst_i(srst_i), .req_i(req_i), .take_i(take_i),
    .vsesr_i(vsesr_i), .scr_ns_i(scr_ns_i), .scr_error_reg_access_trap_i(scr_error_reg_access_trap_i),
    .aux2_err_en_i(aux2_err_en_i), .aux3_err_en_i(aux3_err_en_i),
    .exec_state_flag_i(exec_state_flag_i),
    .rec_selector_i(rec_selector_i), .rec_status_i(rec_status_i),
    .rec_feature_i(rec_feature_i), .rsp_o(rsp_o),
    .taken_valid_o(taken_valid_o), .taken_el_o(taken_el_o),
    .rec_wr_o(rec_wr_o), .rec_idx_o(rec_idx_o), .rec_wdata_o(rec_wdata_o),
    .el1_wide_o(el1_wide_o), .el0_wide_o(el0_wide_o),
    .gen_trap_eff_o(gen_trap_eff_o)
);

// [esyn_top_test.sv]
// Purpose: Self-checking bench for the syndrome and trap unit
// Assumes: Inputs change on the falling edge; answers come one cycle on
// Notes:   A second instance is built without level 2
`timescale 1ns/100ps
module esyn_top_test;
    import esyn_pkg::*;
    logic              mclk_i = 1'b0;
    logic              srst_i = 1'b1;
    esyn_req_t         req_i = '0;
    esyn_take_t        take_i = '0;
    logic       [24:0] vsesr_i = 25'h155_AAAA;
    logic              scr_ns_i = 1'b0;
    logic              scr_error_reg_access_trap_i = 1'b0;
    logic              aux2_err_en_i = 1'b0;
    logic              aux3_err_en_i = 1'b0;
    logic              exec_state_flag_i = 1'b0;
    logic        [0:0] rec_selector_i = 1'h0;
    logic  [1:0][63:0] rec_status_i = {64'h5A5A_0000_0000_1111,
                                       64'hA5A5_0000_0000_2222};
    logic  [1:0][63:0] rec_feature_i = {64'h0F0F_0000_0000_3333,
                                        64'hF0F0_0000_0000_4444};
    esyn_rsp_t         rsp_o;
    esyn_rsp_t         r;
    esyn_rsp_t         rsp2;
    logic              taken_valid_o;
    logic        [1:0] taken_el_o;
    logic              rec_wr_o;
    logic        [0:0] rec_idx_o;
    logic       [63:0] rec_wdata_o;
    logic              el1_wide_o;
    logic              el0_wide_o;
    logic              gen_trap_eff_o;
    int                n_fail = 0;
    int                n_checks = 0;
    int                cyc = 0;

    esyn_top #(.EL2_IMPL(1'b1), .NREC(2)) dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .req_i(req_i), .take_i(take_i),
        .vsesr_i(vsesr_i), .scr_ns_i(scr_ns_i), .scr_error_reg_access_trap_i(scr_error_reg_access_trap_i),
        .aux2_err_en_i(aux2_err_en_i), .aux3_err_en_i(aux3_err_en_i),
        .exec_state_flag_i(exec_state_flag_i),
        .rec_selector_i(rec_selector_i), .rec_status_i(rec_status_i),
        .rec_feature_i(rec_feature_i), .rsp_o(rsp_o),
        .taken_valid_o(taken_valid_o), .taken_el_o(taken_el_o),
        .rec_wr_o(rec_wr_o), .rec_idx_o(rec_idx_o),
        .rec_wdata_o(rec_wdata_o), .el1_wide_o(el1_wide_o),
        .el0_wide_o(el0_wide_o), .gen_trap_eff_o(gen_trap_eff_o)
    );

    // Same stimulus; level 2 absent, so its syndrome must read zero
    esyn_top #(.EL2_IMPL(1'b0), .NREC(2)) dut_nl2 (
        .mclk_i(mclk_i), .srst_i(srst_i), .req_i(req_i), .take_i(take_i),
        .vsesr_i(vsesr_i), .scr_ns_i(scr_ns_i), .scr_error_reg_access_trap_i(scr_error_reg_access_trap_i),
        .aux2_err_en_i(aux2_err_en_i), .aux3_err_en_i(aux3_err_en_i),
        .exec_state_flag_i(exec_state_flag_i),
        .rec_selector_i(rec_selector_i), .rec_status_i(rec_status_i),
        .rec_feature_i(rec_feature_i), .rsp_o(rsp2), .taken_valid_o(),
        .taken_el_o(), .rec_wr_o(), .rec_idx_o(), .rec_wdata_o(),
        .el1_wide_o(), .el0_wide_o(), .gen_trap_eff_o()
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One access: request held for one edge, answer sampled a cycle on
    task automatic acc(input esyn_reg_t s, input logic [1:0] e,
                       input logic w, input logic [63:0] d);
        @(negedge mclk_i);
        req_i <= '{1'b1, w, s, e, d};
        @(negedge mclk_i);
        r = rsp_o;
        req_i.valid <= 1'b0;
    endtask

    // f holds isv, synv, unrec, virt from top bit down
    task automatic tk(input logic [1:0] t, input logic [5:0] c,
                      input logic l, input esyn_kind_t k,
                      input logic [3:0] f, input logic [24:0] i);
        @(negedge mclk_i);
        take_i <= '{1'b1, t, c, l, k, f[3], f[2], f[1], f[0], i};
        @(negedge mclk_i);
        take_i.valid <= 1'b0;
        chk(taken_valid_o, 64'h1);
    endtask

    function automatic logic [63:0] syn13(input logic [5:0] c,
        input logic l, input esyn_kind_t k, input logic abort_syndrome_valid,
        input logic v, input logic [24:0] i);
        logic il;
        il = l || c == 6'h00 || (k == EK_DABT && !abort_syndrome_valid)
             || !(k inside {EK_SYNC, EK_DABT});
        return {32'h0, c, il, v, v ? i[23:0] : 24'h0};
    endfunction

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // Cut a hang short well past the few hundred cycles needed
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        logic [5:0]  c;
        logic [1:0]  e;
        logic        u;
        logic        t2;
        logic        t3;
        logic [1:0]  t;
        repeat (20) @(negedge mclk_i);
        srst_i = 1'b0;
        for (int k = 0; k < 7; k++) begin
            for (int b = 0; b < 4; b++) begin
                c = k == 1 ? 6'h2F : (k == 0 && b == 2) ? 6'h00 : 6'h20 | k;
                t = b[0] ? EL1 : EL3;
                tk(t, c, b[0], esyn_kind_t'(k), {b[1], b != 1, 2'b00},
                   25'h1A5_5A5A ^ k);
                chk(taken_el_o, t);
                acc(b[0] ? REG_SYN1 : REG_SYN3, t, 1'b0, 64'h0);
                chk(r.rdata, syn13(c, b[0], esyn_kind_t'(k), b[1], b != 1,
                    25'h1A5_5A5A ^ k));
            end
        end
        acc(REG_SYN1, EL1, 1'b1, 64'hFEFF_FFFF);
        acc(REG_SYN1, EL1, 1'b0, 64'h0);
        chk(r.rdata, 64'hFE00_0000);
        tk(EL2, 6'h2F, 1'b1, EK_SERR, 4'b0101, 25'h0);
        acc(REG_SYN2, EL3, 1'b0, 64'h0);
        chk(r.rdata[24:0], vsesr_i);
        chk({rsp2.valid, rsp2.undef, rsp2.rdata}, {2'b10, 64'h0});
        for (int q = 0; q < 2; q++) begin
            tk(EL2, 6'h2F, 1'b1, EK_SERR, {2'b01, !q[0], 1'b0},
               25'h1FF_FFFF);
            acc(REG_SYN2, EL2, 1'b0, 64'h0);
            chk(r.rdata & 64'h0100_1E00, q ? 64'h0 : 64'h0400);
        end
        tk(EL2, 6'h24, 1'b1, EK_DABT, 4'b1100, 25'h1FF_FFFF);
        acc(REG_SYN2, EL2, 1'b0, 64'h0);
        chk(r.rdata[9], 64'h0);
        acc(REG_HCFG, EL2, 1'b1, '1);
        acc(REG_HCFG, EL2, 1'b0, 64'h0);
        chk(r.rdata, 64'h0000_003F_DFFF_FFFF);
        acc(REG_HAUX, EL2, 1'b1, '1);
        acc(REG_HAUX, EL2, 1'b0, 64'h0);
        chk(r.rdata, 64'h0);
        exec_state_flag_i = 1'b1;
        scr_ns_i = 1'b1;
        acc(REG_HAUX, EL3, 1'b0, 64'h0);
        chk({el1_wide_o, el0_wide_o, gen_trap_eff_o}, 3'b101);
        exec_state_flag_i = 1'b0;
        tk(EL1, 6'h15, 1'b1, EK_SYNC, 4'b0100, 25'h0);
        chk({el0_wide_o, taken_el_o}, {1'b1, EL2});
        scr_ns_i = 1'b0;
        tk(EL1, 6'h15, 1'b1, EK_SYNC, 4'b0100, 25'h0);
        chk({gen_trap_eff_o, taken_el_o}, {1'b0, EL1});
        for (int h = 0; h < 2; h++) begin
            acc(REG_HCFG, EL2, 1'b1, h ? 64'h10_0000_0000 : 64'h0);
            rec_selector_i = h[0];
            for (int n = 0; n < 64; n++) begin
                e = n[5:4];
                {aux2_err_en_i, aux3_err_en_i, scr_error_reg_access_trap_i, scr_ns_i} = n[3:0];
                u = e == EL0 || (e == EL1 && !(n[3] && n[2]))
                    || (e == EL2 && !n[2]);
                t2 = !u && e == EL1 && h && n[0];
                t3 = !u && !t2 && e != EL3 && n[1];
                acc(REG_PFGF, e, 1'b0, 64'h0);
                chk({r.undef, r.trap2, r.trap3}, {u, t2, t3});
                chk(r.rdata, (u || t2 || t3) ? 64'h0 : rec_feature_i[h]);
            end
        end
        for (int i = 0; i < 2; i++) begin
            rec_selector_i = i[0];
            acc(REG_RSTS, EL1, 1'b0, 64'h0);
            chk(r.rdata, rec_status_i[i]);
            acc(REG_RSTS, EL1, 1'b1, 64'hC0DE_0000_0000_0001 + i);
            chk({rec_wr_o, rec_idx_o}, {1'b1, i[0]});
            chk(rec_wdata_o, 64'hC0DE_0000_0000_0001 + i);
        end
        end_sim();
    end
endmodule
